// file: spipr_port.sv
module spipr_port (
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic        spi_sclk,
    input  wire logic        spi_cs_n,
    input  wire logic        serial_data_in,
    input  wire logic        sdio_in,
    output logic             sdio_out,
    output logic             sdio_oe,
    input  wire logic        cfg_three_wire,
    input  wire logic        cfg_sample_falling,
    input  wire logic        cfg_read_delay,
    input  wire logic        cfg_two_byte,
    output logic [15:0]      reg_addr,
    output logic [7:0]       reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    input  wire logic [7:0]  reg_rdata
);

    logic [2:0]              sclk_s;
    logic [1:0]              cs_s, sdi_s, sdio_s;
    logic                    mode_three, mode_fall, mode_delay, mode_two;
    logic [2:0]              bit_cnt;
    logic [6:0]              rx_sh;
    logic [14:0]             ptr;
    spipr_pkg::spipr_phase_t phase;
    logic [31:0]             page_short;
    logic [23:0]             page_long;
    logic                    is_read, fetch_go, fetch2, fetch3, launch_pend;
    logic [7:0]              tx_byte;

    // True when the offset hits one of the page select bytes.
    function automatic logic is_page(input logic [14:0] p,
                                     input logic two);
        is_page = two ? (p >= spipr_pkg::PAGE_LONG_BASE)
                      : (p[6:0] >= spipr_pkg::PAGE_SHORT_BASE);
    endfunction : is_page

    // Byte index inside the page select register for a page offset.
    function automatic logic [1:0] page_idx(input logic [14:0] p,
                                            input logic two);
        page_idx = two ? (p[1:0] - 2'h1) : p[1:0];
    endfunction : page_idx

    // Full register address from page bits and the offset pointer.
    function automatic logic [15:0] full_addr(input logic [14:0] p,
                                              input logic two,
                                              input logic [31:0] ps,
                                              input logic [23:0] pl);
        full_addr = two ? {pl[7], p} : {ps[15:8], ps[7], p[6:0]};
    endfunction : full_addr

    // Pin inputs pass two flip-flops; the clock keeps a third for edges.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sclk_s <= 3'h0;
            cs_s   <= 2'h3;
            sdi_s  <= 2'h0;
            sdio_s <= 2'h0;
        end else begin
            sclk_s <= {sclk_s[1:0], spi_sclk};
            cs_s   <= {cs_s[0], spi_cs_n};
            sdi_s  <= {sdi_s[0], serial_data_in};
            sdio_s <= {sdio_s[0], sdio_in};
        end
    end

    // Configuration copies start in four-wire, rising, no delay, 1B.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_three <= spipr_pkg::CFG_RESET;
            mode_fall  <= spipr_pkg::CFG_RESET;
            mode_delay <= spipr_pkg::CFG_RESET;
            mode_two   <= spipr_pkg::CFG_RESET;
        end else begin
            mode_three <= cfg_three_wire;
            mode_fall  <= cfg_sample_falling;
            mode_delay <= cfg_read_delay;
            mode_two   <= cfg_two_byte;
        end
    end

    logic       cs_act, sclk_rise, sclk_fall, sample_edge, launch_edge;
    logic       din, byte_done, rd_now, enter_data;
    logic [7:0] rx_byte;

    // Edge selection, data pin selection and byte framing.
    assign cs_act      = ~cs_s[1];
    assign sclk_rise   = sclk_s[1] & ~sclk_s[2];
    assign sclk_fall   = ~sclk_s[1] & sclk_s[2];
    assign sample_edge = mode_fall ? sclk_fall : sclk_rise;
    assign launch_edge = mode_delay ? (mode_fall ? sclk_rise : sclk_fall)
                                    : sample_edge;
    assign din         = mode_three ? sdio_s[1] : sdi_s[1];
    assign rx_byte     = {rx_sh, din};
    assign byte_done   = cs_act & sample_edge
                         & (bit_cnt == spipr_pkg::LAST_BIT);
    assign rd_now      = (phase == spipr_pkg::PH_CMD_HI)
                         ? (rx_byte[spipr_pkg::DIR_BIT] == spipr_pkg::DIR_READ)
                         : is_read;
    assign enter_data  = byte_done & (((phase == spipr_pkg::PH_CMD_HI)
                         & ~mode_two) | (phase == spipr_pkg::PH_CMD_LO));

    // Bit counter and receive shifter; a frame end drops a partial byte.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            bit_cnt <= 3'h0;
            rx_sh   <= 7'h00;
        end else if (!cs_act) begin
            bit_cnt <= 3'h0;
            rx_sh   <= 7'h00;
        end else if (sample_edge) begin
            bit_cnt <= bit_cnt + 3'h1;
            rx_sh   <= rx_byte[6:0];
        end
    end

    // Command decode and the auto-incrementing offset pointer.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            phase   <= spipr_pkg::PH_CMD_HI;
            is_read <= 1'b0;
            ptr     <= 15'h0000;
        end else if (!cs_act) begin
            phase   <= spipr_pkg::PH_CMD_HI;
        end else if (byte_done) begin
            case (phase)
                spipr_pkg::PH_CMD_HI: begin
                    is_read <= rd_now;
                    if (mode_two) begin
                        ptr   <= {rx_byte[6:0], 8'h00};
                        phase <= spipr_pkg::PH_CMD_LO;
                    end else begin
                        ptr   <= {8'h00, rx_byte[6:0]};
                        phase <= spipr_pkg::PH_DATA;
                    end
                end
                spipr_pkg::PH_CMD_LO: begin
                    ptr[7:0] <= rx_byte;
                    phase    <= spipr_pkg::PH_DATA;
                end
                spipr_pkg::PH_DATA: begin
                    ptr <= ptr + 15'h0001;
                end
                default: begin
                    phase <= spipr_pkg::PH_CMD_HI;
                end
            endcase
        end
    end

    // Page select registers take write bytes aimed at their offsets.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            page_short <= spipr_pkg::PAGE_SHORT_RESET;
            page_long  <= spipr_pkg::PAGE_LONG_RESET;
        end else if (byte_done && phase == spipr_pkg::PH_DATA && !is_read
                     && is_page(ptr, mode_two)) begin
            if (mode_two) begin
                page_long[{page_idx(ptr, 1'b1), 3'h0} +: 8] <= rx_byte;
            end else begin
                page_short[{page_idx(ptr, 1'b0), 3'h0} +: 8] <= rx_byte;
            end
        end
    end

    // Register port: write strobes, read strobes and the composed address.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_addr  <= 16'h0000;
            reg_wdata <= 8'h00;
            reg_wr    <= 1'b0;
            reg_rd    <= 1'b0;
        end else begin
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
            if (byte_done && phase == spipr_pkg::PH_DATA && !is_read
                && !is_page(ptr, mode_two)) begin
                reg_addr  <= full_addr(ptr, mode_two, page_short, page_long);
                reg_wdata <= rx_byte;
                reg_wr    <= 1'b1;
            end else if (fetch_go) begin
                reg_addr <= full_addr(ptr, mode_two, page_short, page_long);
                reg_rd   <= ~is_page(ptr, mode_two);
            end
        end
    end

    // Read fetch: the store answers the cycle after the strobe, so the
    // capture waits one cycle past the strobe cycle.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            fetch_go <= 1'b0;
            fetch2   <= 1'b0;
            fetch3   <= 1'b0;
            tx_byte  <= 8'h00;
        end else begin
            fetch_go <= byte_done & rd_now
                        & (enter_data | (phase == spipr_pkg::PH_DATA));
            fetch2   <= fetch_go;
            fetch3   <= fetch2;
            if (fetch3) begin
                if (is_page(ptr, mode_two)) begin
                    tx_byte <= mode_two
                        ? page_long[{page_idx(ptr, 1'b1), 3'h0} +: 8]
                        : page_short[{page_idx(ptr, 1'b0), 3'h0} +: 8];
                end else begin
                    tx_byte <= reg_rdata;
                end
            end
        end
    end

    // Launch of read bits on the chosen edge, waiting out a pending fetch.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            launch_pend <= 1'b0;
            sdio_out    <= 1'b0;
        end else if (!cs_act) begin
            launch_pend <= 1'b0;
        end else if (launch_edge && rd_now
                     && (enter_data || phase == spipr_pkg::PH_DATA)) begin
            launch_pend <= 1'b1;
        end else if (launch_pend && !fetch_go && !fetch2 && !fetch3) begin
            launch_pend <= 1'b0;
            sdio_out    <= tx_byte[3'h7 - bit_cnt];
        end
    end

    // The data pin is driven only during read data of an active frame.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sdio_oe <= 1'b0;
        end else begin
            sdio_oe <= cs_act & is_read & (phase == spipr_pkg::PH_DATA);
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    // A page byte write: last bit of a data byte aimed at a page offset.
    sequence s_short_hi_wr;
        byte_done && phase == spipr_pkg::PH_DATA && !is_read && !mode_two
        && ptr[6:0] == 7'h7D;
    endsequence
    sequence s_long_lo_wr;
        byte_done && phase == spipr_pkg::PH_DATA && !is_read && mode_two
        && ptr == 15'h7FFD;
    endsequence

    a_cs_release_hiz: assert property (!cs_act |=> !sdio_oe)
        else $error("data pin still driven after chip select rose");
    a_partial_drop: assert property (!cs_act |=> bit_cnt == 3'h0
        && phase == spipr_pkg::PH_CMD_HI)
        else $error("bit counter or phase kept across frame end");
    a_ptr_step: assert property (byte_done && phase == spipr_pkg::PH_DATA
        |=> ptr == $past(ptr) + 15'h0001)
        else $error("pointer did not step by one");
    a_dir_decode: assert property (byte_done && phase == spipr_pkg::PH_CMD_HI
        |=> is_read == $past(rx_byte[7]))
        else $error("direction flag decoded wrongly");
    a_short_page_set: assert property (s_short_hi_wr
        |=> page_short[15:8] == $past(rx_byte))
        else $error("short page byte not stored");
    a_long_page_set: assert property (s_long_lo_wr
        |=> page_long[7:0] == $past(rx_byte))
        else $error("long page byte not stored");
    a_delay_no_launch: assert property (mode_delay && sample_edge
        && !launch_pend |=> !launch_pend)
        else $error("delayed launch armed on the sample edge");
    a_short_addr: assert property (reg_rd && !mode_two
        |-> reg_addr[15:7] == {page_short[15:8], page_short[7]})
        else $error("1B address upper bits not from page");
    a_long_addr: assert property (reg_rd && mode_two
        |-> reg_addr[15] == page_long[7])
        else $error("2B address upper bit not from page");
    a_four_wire_in: assert property (cs_act && !mode_three && sample_edge
        |=> rx_sh[0] == $past(sdi_s[1]))
        else $error("four-wire mode did not sample the input line");
    a_edge_select: assert property (cs_act && mode_fall && sclk_rise
        |=> bit_cnt == $past(bit_cnt))
        else $error("falling mode sampled on a rising edge");

endmodule : spipr_port

// file: spipr_pkg.sv
package spipr_pkg;

    // Offsets of the page select registers inside the command offset field.
    localparam logic [6:0]  PAGE_SHORT_BASE  = 7'h7C;
    localparam logic [14:0] PAGE_LONG_BASE   = 15'h7FFD;

    // Reset values of the page select registers.
    localparam logic [31:0] PAGE_SHORT_RESET = 32'h00000000;
    localparam logic [23:0] PAGE_LONG_RESET  = 24'h000000;

    // Field positions inside the first command byte.
    localparam int          DIR_BIT          = 7;
    localparam logic        DIR_READ         = 1'b1;

    // Bit counter value of the last bit of a byte.
    localparam logic [2:0]  LAST_BIT         = 3'h7;

    // Configuration reset values: four-wire, rising edge, no delay, 1B.
    localparam logic        CFG_RESET        = 1'b0;

    // Transfer phases of one chip select frame.
    typedef enum logic [1:0] {
        PH_CMD_HI = 2'b00,
        PH_CMD_LO = 2'b01,
        PH_DATA   = 2'b10
    } spipr_phase_t;

endpackage : spipr_pkg

// file: spipr_host.sv
module spipr_host (
    input  wire logic three_wire,
    input  wire logic sample_falling,
    input  wire logic read_delay,
    input  wire logic sdio_out,
    input  wire logic sdio_oe,
    output logic      spi_sclk,
    output logic      spi_cs_n,
    output logic      serial_data_in,
    output logic      sdio_in
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam time HALF = 24ns;
    logic host_d;

    // The shared pin follows its driver and is pulled up when both release.
    assign sdio_in = sdio_oe ? sdio_out : (spi_cs_n ? 1'b1 : host_d);
    // In three-wire mode the unused serial input carries the inverse so it never mirrors real data.
    assign serial_data_in = three_wire ? ~host_d : host_d;

    // The serial clock rests between frames and the bus starts released.
    initial begin
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
        host_d   = 1'b0;
    end

    // Idle level is chosen so the first change is the sampling edge.
    task automatic start();
        spi_sclk = sample_falling;
        #(HALF);
        spi_cs_n = 1'b0;
        #(HALF);
    endtask : start

    // Releasing the frame leaves the data line showing a stale inverse.
    task automatic stop();
        #(HALF);
        spi_cs_n = 1'b1;
        host_d   = ~host_d;
        #(HALF);
    endtask : stop

    // Shifts nbits of tx out MSB first and gathers the device's bits.
    task automatic xfer(input logic [7:0] tx, input int nbits,
                        output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - nbits; i--) begin
            host_d = tx[i];
            #(HALF);
            spi_sclk = ~spi_sclk;
            if (!read_delay) rx[i] = sdio_out;
            #(HALF);
            if (read_delay) rx[i] = sdio_out;
            spi_sclk = ~spi_sclk;
        end
    endtask : xfer
endmodule : spipr_host

// file: spipr_port_tb.sv
module spipr_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk, reset_n, spi_sclk, spi_cs_n, serial_data_in;
    logic        sdio_in, sdio_out, sdio_oe, reg_wr, reg_rd, oe_mid, oe_end;
    logic        cfg_three_wire, cfg_sample_falling, cfg_read_delay;
    logic        cfg_two_byte;
    logic [15:0] reg_addr;
    logic [7:0]  reg_wdata, reg_rdata;
    logic [7:0]  rxq[$];
    logic [23:0] wlog[$];
    int          n_mismatch, cmp_count;

    spipr_port dut (.ref_clk(ref_clk), .reset_n(reset_n),
        .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .serial_data_in(serial_data_in), .sdio_in(sdio_in),
        .sdio_out(sdio_out), .sdio_oe(sdio_oe),
        .cfg_three_wire(cfg_three_wire),
        .cfg_sample_falling(cfg_sample_falling),
        .cfg_read_delay(cfg_read_delay), .cfg_two_byte(cfg_two_byte),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    spipr_host host (.three_wire(cfg_three_wire),
        .sample_falling(cfg_sample_falling), .read_delay(cfg_read_delay),
        .sdio_out(sdio_out), .sdio_oe(sdio_oe), .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n), .serial_data_in(serial_data_in),
        .sdio_in(sdio_in));

    // The system clock toggles every half period.
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    function automatic logic [7:0] rd_value(input logic [15:0] a);
        return a[15:8] + a[7:0];
    endfunction : rd_value

    // The register store answers a cycle after a read and logs writes.
    always @(posedge ref_clk) begin
        if (reg_rd) reg_rdata <= rd_value(reg_addr);
        if (reg_wr) wlog.push_back({reg_addr, reg_wdata});
    end

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic set_cfg(input logic tw, sf, rd, two);
        @(posedge ref_clk);
        cfg_three_wire     <= tw;
        cfg_sample_falling <= sf;
        cfg_read_delay     <= rd;
        cfg_two_byte       <= two;
        repeat (4) @(posedge ref_clk);
    endtask : set_cfg

    // One whole burst under a single select; the odd offset keeps the
    // serial edges away from the system clock edges.
    task automatic frame(input logic [7:0] b[$]);
        logic [7:0] r;
        @(posedge ref_clk);
        #1;
        rxq.delete();
        host.start();
        foreach (b[i]) begin
            host.xfer(b[i], 8, r);
            rxq.push_back(r);
        end
        oe_mid = sdio_oe;
        host.stop();
        oe_end = sdio_oe;
        repeat (8) @(posedge ref_clk);
    endtask : frame

    task automatic t_write_1b();
        set_cfg(1'b0, 1'b0, 1'b0, 1'b0);
        frame('{8'h7C, 8'h80, 8'hCB, 8'h10, 8'h20});
        check(24'(wlog.size()), 24'h0);
        frame('{8'h64, 8'h50, 8'h51});
        check(24'(wlog.size()), 24'h2);
        check(wlog[0], {16'hCBE4, 8'h50});
        check(wlog[1], {16'hCBE5, 8'h51});
        wlog.delete();
        $display("short offset write test done");
    endtask : t_write_1b

    task automatic t_read_1b();
        frame('{8'h7C, 8'h00, 8'hC0, 8'h10, 8'h20});
        frame('{8'hA4, 8'h00, 8'h00});
        check(24'(rxq[1]), 24'(rd_value(16'hC024)));
        check(24'(rxq[2]), 24'(rd_value(16'hC025)));
        check(24'(oe_mid), 24'h1);
        check(24'(oe_end), 24'h0);
        check(24'(wlog.size()), 24'h0);
        $display("short offset read test done");
    endtask : t_read_1b

    task automatic t_long_3wire();
        set_cfg(1'b1, 1'b0, 1'b1, 1'b1);
        frame('{8'h7F, 8'hFD, 8'h80, 8'h10, 8'h20});
        frame('{8'h4B, 8'hE4, 8'h50});
        check(24'(wlog.size()), 24'h1);
        check(wlog[0], {16'hCBE4, 8'h50});
        frame('{8'hC0, 8'h24, 8'h00, 8'h00});
        check(24'(rxq[2]), 24'(rd_value(16'hC024)));
        check(24'(rxq[3]), 24'(rd_value(16'hC025)));
        check(24'(oe_end), 24'h0);
        wlog.delete();
        $display("long offset three-wire test done");
    endtask : t_long_3wire

    task automatic t_abort_falling();
        logic [7:0] r;
        set_cfg(1'b0, 1'b1, 1'b0, 1'b0);
        frame('{8'h7C, 8'h80, 8'hCB, 8'h10, 8'h20});
        #1;
        host.start();
        host.xfer(8'hFF, 5, r);
        host.stop();
        frame('{8'h64, 8'h5A});
        check(24'(wlog.size()), 24'h1);
        check(wlog[0], {16'hCBE4, 8'h5A});
        frame('{8'hE4, 8'h00});
        check(24'(rxq[1]), 24'(rd_value(16'hCBE4)));
        $display("abort and falling edge test done");
    endtask : t_abort_falling

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    // Main sequence: reset, then each scenario in turn.
    initial begin
        reset_n            = 1'b0;
        cfg_three_wire     = 1'b0;
        cfg_sample_falling = 1'b0;
        cfg_read_delay     = 1'b0;
        cfg_two_byte       = 1'b0;
        reg_rdata          = 8'h00;
        n_mismatch         = 0;
        cmp_count          = 0;
        repeat (8) @(posedge ref_clk);
        reset_n <= 1'b1;
        check({reg_addr, 5'h00, reg_wr, reg_rd, sdio_oe}, 24'h0);
        repeat (4) @(posedge ref_clk);
        t_write_1b();
        t_read_1b();
        t_long_3wire();
        t_abort_falling();
        report_and_stop();
    end

    // A hang is cut short well after the scenarios should have ended.
    initial begin
        #100us;
        n_mismatch++;
        report_and_stop();
    end
endmodule : spipr_port_tb
